// ===== ppal_top.sv
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "ppal_cfg.svh"

// What this block does
// [RQ1] Color bar k sends palette byte k
// [RQ2] Fixed pattern emits bytes 0..14 in order (here 0..flast, with flast 14 at reset)
// [RQ3] Bars stop at 7; bytes 8-14 fixed only
// [RQ4] Bytes 3,4,5,7 reset to documented values
// [RQ5] Byte 7 serves bar 7 and eighth byte
// [RQ6] Bytes 0,1 serve bars 0,1 and first two
// [RQ7] Palette writes apply to next bytes, no restart

module ppal_top #(
    parameter int         ADDR_W     = 8,
    parameter logic [7:0] UNSPEC_RST = 8'h00
) (
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    input  wire logic                 hsel,
    input  wire logic [ADDR_W-1:0]    haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic                 hready,
    input  wire logic [31:0]          hwdata,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic                 pat_line_start,
    input  wire logic                 pat_ready,
    output logic                      pat_valid,
    output ppal_pkg::ppal_byte_t      pat_byte,
    output ppal_pkg::ppal_mode_t      pat_mode
);
    import ppal_pkg::*;

    // ----------------------------------------
    // Reset table
    // ----------------------------------------
    // Bytes other than 0, 3, 4, 5, 7 and 11 share one parameter.
    function automatic logic [7:0] rst_of(input int i);
        logic [7:0] v;
        v = UNSPEC_RST;
        case (i)
            0:       v = `PPAL_RST_BYTE0;
            3:       v = `PPAL_RST_BYTE3;   // [RQ4]
            4:       v = `PPAL_RST_BYTE4;   // [RQ4]
            5:       v = `PPAL_RST_BYTE5;   // [RQ4]
            7:       v = `PPAL_RST_BYTE7;   // [RQ4] [RQ5]
            11:      v = `PPAL_RST_BYTE11;
            default: v = UNSPEC_RST;
        endcase
        return v;
    endfunction

    // ----------------------------------------
    // Bus slave: address phase capture
    // ----------------------------------------
    logic                   acc;
    logic [`PPAL_IDX_W-1:0] a_idx;
    logic                   wr_pend_reg;
    logic [`PPAL_IDX_W-1:0] wr_idx_reg;
    logic [31:0]            hrdata_reg;
    logic [31:0]            rd_next;

    assign acc   = hsel & hready & htrans[1];
    assign a_idx = haddr[`PPAL_IDX_W+1:2];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= '0;
        end else if (hready) begin
            wr_pend_reg <= acc & hwrite;
            wr_idx_reg  <= a_idx;
        end
    end

    // Zero wait states and no error response for any address
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ----------------------------------------
    // Palette storage
    // ----------------------------------------
    ppal_byte_t palette [`PPAL_NUM_BYTES];

    genvar gi;
    generate
        for (gi = 0; gi < `PPAL_NUM_BYTES; gi++) begin : g_pal
            localparam logic [`PPAL_IDX_W-1:0] IDX =
                `PPAL_IDX_W'(`PPAL_IDX_BYTE0 + gi);
            ppal_byte_reg #(
                .RST(rst_of(gi))
            ) u_byte (
                .mclk  (mclk),
                .nrst  (nrst),
                .we    (wr_pend_reg && (wr_idx_reg == IDX)),
                .wdata (hwdata[7:0]),
                .q     (palette[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] ctrl_next;

    assign ctrl_next = hwdata & `PPAL_CTRL_MASK;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= `PPAL_CTRL_RST;
        end else if (wr_pend_reg && (wr_idx_reg == `PPAL_IDX_CTRL)) begin
            ctrl_reg <= ctrl_next;
        end
    end

    ppal_mode_t mode_sel;
    logic [3:0] flast_raw;
    logic [3:0] flast;
    logic [7:0] bar_w;

    assign mode_sel  = ppal_mode_t'(ctrl_reg[`PPAL_CTRL_MODE_MSB:`PPAL_CTRL_MODE_LSB]);
    assign flast_raw = ctrl_reg[`PPAL_CTRL_FLAST_MSB:`PPAL_CTRL_FLAST_LSB];
    assign bar_w     = ctrl_reg[`PPAL_CTRL_BARW_MSB:`PPAL_CTRL_BARW_LSB];
    // The reserved slot never joins the fixed pattern
    assign flast     = (flast_raw > `PPAL_LAST_FIXED) ? `PPAL_LAST_FIXED : flast_raw;
    assign pat_mode  = mode_sel;

    // ----------------------------------------
    // Pattern generator
    // ----------------------------------------
    ppal_gen_t  gen_state_reg;
    ppal_gen_t  gen_target;
    logic [2:0] bar_idx_reg;
    logic [7:0] bar_cnt_reg;
    logic [3:0] fix_idx_reg;
    logic       pat_valid_reg;
    ppal_byte_t pat_byte_reg;
    logic       advance;
    logic [2:0] cur_bar;
    logic [7:0] cur_cnt;
    logic [3:0] cur_fix;
    logic       emit_bar;
    logic       emit_fix;

    always_comb begin
        case (mode_sel)
            PPAL_MODE_BAR:   gen_target = PPAL_GEN_BAR;
            PPAL_MODE_FIXED: gen_target = PPAL_GEN_FIXED;
            default:         gen_target = PPAL_GEN_IDLE;
        endcase
    end

    assign advance  = !pat_valid_reg || pat_ready;
    assign emit_bar = advance && (gen_state_reg == PPAL_GEN_BAR) &&
                      (gen_target == PPAL_GEN_BAR);
    assign emit_fix = advance && (gen_state_reg == PPAL_GEN_FIXED) &&
                      (gen_target == PPAL_GEN_FIXED);

    // A line start restarts both sequences at their first byte
    assign cur_bar = pat_line_start ? 3'h0 : bar_idx_reg;
    assign cur_cnt = pat_line_start ? 8'h00 : bar_cnt_reg;
    assign cur_fix = pat_line_start ? 4'h0 : fix_idx_reg;

    // Mode changes always pass through idle so counters restart cleanly
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gen_state_reg <= PPAL_GEN_IDLE;
        end else begin
            case (gen_state_reg)
                PPAL_GEN_IDLE: begin
                    gen_state_reg <= gen_target;
                end
                PPAL_GEN_BAR, PPAL_GEN_FIXED: begin
                    if (gen_target != gen_state_reg) begin
                        gen_state_reg <= PPAL_GEN_IDLE;
                    end
                end
                default: begin
                    gen_state_reg <= PPAL_GEN_IDLE;
                end
            endcase
        end
    end

    // Bar position: bar_w + 1 bytes per bar, eight bars then wrap
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bar_idx_reg <= 3'h0;
            bar_cnt_reg <= 8'h00;
        end else if (gen_state_reg != PPAL_GEN_BAR) begin
            bar_idx_reg <= 3'h0;
            bar_cnt_reg <= 8'h00;
        end else if (emit_bar) begin
            if (cur_cnt >= bar_w) begin
                bar_cnt_reg <= 8'h00;
                bar_idx_reg <= (cur_bar == `PPAL_LAST_BAR) ? 3'h0 : cur_bar + 3'h1;  // [RQ3]
            end else begin
                bar_cnt_reg <= cur_cnt + 8'h01;
                bar_idx_reg <= cur_bar;
            end
        end else if (pat_line_start) begin
            bar_idx_reg <= 3'h0;
            bar_cnt_reg <= 8'h00;
        end
    end

    // Fixed position: ascending byte index, wrap after the last one
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fix_idx_reg <= 4'h0;
        end else if (gen_state_reg != PPAL_GEN_FIXED) begin
            fix_idx_reg <= 4'h0;
        end else if (emit_fix) begin
            fix_idx_reg <= (cur_fix >= flast) ? 4'h0 : cur_fix + 4'h1;  // [RQ2]
        end else if (pat_line_start) begin
            fix_idx_reg <= 4'h0;
        end
    end

    // Palette is read when each byte is issued, so writes land on the next byte
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pat_valid_reg <= 1'b0;
            pat_byte_reg  <= 8'h00;
        end else if (emit_bar) begin
            pat_valid_reg <= 1'b1;
            pat_byte_reg  <= palette[cur_bar];  // [RQ1] [RQ3] [RQ5] [RQ6] [RQ7]
        end else if (emit_fix) begin
            pat_valid_reg <= 1'b1;
            pat_byte_reg  <= palette[cur_fix];  // [RQ2] [RQ5] [RQ6] [RQ7]
        end else if (advance) begin
            pat_valid_reg <= 1'b0;
        end
    end

    assign pat_valid = pat_valid_reg;
    assign pat_byte  = pat_byte_reg;

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [31:0] status_word;

    assign status_word = {21'h0, pat_valid_reg, gen_state_reg, fix_idx_reg, 1'b0, bar_idx_reg};

    // A palette or control write in its data phase is forwarded to a read of the same word
    always_comb begin
        rd_next = 32'h0;
        if (a_idx >= `PPAL_IDX_BYTE0 && a_idx < `PPAL_IDX_RSVD) begin
            if (wr_pend_reg && wr_idx_reg == a_idx) begin
                rd_next = {24'h0, hwdata[7:0]};
            end else begin
                rd_next = {24'h0, palette[4'(a_idx - `PPAL_IDX_BYTE0)]};
            end
        end else if (a_idx == `PPAL_IDX_RSVD) begin
            rd_next = {24'h0, `PPAL_RST_RSVD};
        end else if (a_idx == `PPAL_IDX_CTRL) begin
            if (wr_pend_reg && wr_idx_reg == a_idx) begin
                rd_next = ctrl_next;
            end else begin
                rd_next = ctrl_reg;
            end
        end else if (a_idx == `PPAL_IDX_STATUS) begin
            rd_next = status_word;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hrdata_reg <= 32'h0;
        end else if (acc && !hwrite) begin
            hrdata_reg <= rd_next;
        end
    end

    assign hrdata = hrdata_reg;

    // Only word transfers are expected; narrower writes still load the low byte
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, htrans[0]};

endmodule

// ===== ppal_cfg.svh
`ifndef PPAL_CFG_SVH
`define PPAL_CFG_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define PPAL_IDX_W          6
`define PPAL_IDX_BYTE0      6'h10
`define PPAL_IDX_BYTE1      6'h11
`define PPAL_IDX_BYTE2      6'h12
`define PPAL_IDX_BYTE3      6'h13
`define PPAL_IDX_BYTE4      6'h14
`define PPAL_IDX_BYTE5      6'h15
`define PPAL_IDX_BYTE6      6'h16
`define PPAL_IDX_BYTE7      6'h17
`define PPAL_IDX_BYTE8      6'h18
`define PPAL_IDX_BYTE9      6'h19
`define PPAL_IDX_BYTE10     6'h1a
`define PPAL_IDX_BYTE11     6'h1b
`define PPAL_IDX_BYTE12     6'h1c
`define PPAL_IDX_BYTE13     6'h1d
`define PPAL_IDX_BYTE14     6'h1e
`define PPAL_IDX_RSVD       6'h1f
`define PPAL_IDX_CTRL       6'h20
`define PPAL_IDX_STATUS     6'h21

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PPAL_RST_BYTE0      8'haa
`define PPAL_RST_BYTE3      8'h7f
`define PPAL_RST_BYTE4      8'h55
`define PPAL_RST_BYTE5      8'hcc
`define PPAL_RST_BYTE7      8'h80
`define PPAL_RST_BYTE11     8'h00
`define PPAL_RST_RSVD       8'h00
`define PPAL_CTRL_RST       32'h000f_0e00

// ----------------------------------------
// Control fields and pattern limits
// ----------------------------------------
`define PPAL_CTRL_MODE_LSB  0
`define PPAL_CTRL_MODE_MSB  1
`define PPAL_CTRL_FLAST_LSB 8
`define PPAL_CTRL_FLAST_MSB 11
`define PPAL_CTRL_BARW_LSB  16
`define PPAL_CTRL_BARW_MSB  23
`define PPAL_CTRL_MASK      32'h00ff_0f03
`define PPAL_NUM_BYTES      15
`define PPAL_LAST_BAR       3'h7
`define PPAL_LAST_FIXED     4'he

`endif

// ===== ppal_pkg.sv
package ppal_pkg;

    // Pattern selection written by software
    typedef enum logic [1:0] {
        PPAL_MODE_OFF   = 2'h0,
        PPAL_MODE_BAR   = 2'h1,
        PPAL_MODE_FIXED = 2'h2,
        PPAL_MODE_RSVD  = 2'h3
    } ppal_mode_t;

    // Generator states, Gray along idle -> bar -> fixed
    typedef enum logic [1:0] {
        PPAL_GEN_IDLE  = 2'b00,
        PPAL_GEN_BAR   = 2'b01,
        PPAL_GEN_FIXED = 2'b11
    } ppal_gen_t;

    typedef logic [7:0] ppal_byte_t;

endpackage

// ===== ppal_byte_reg.sv
`timescale 1ns/1ps

module ppal_byte_reg #(
    parameter logic [7:0] RST = 8'h00
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       we,
    input  wire logic [7:0] wdata,
    output logic      [7:0] q
);

    logic [7:0] q_reg;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q_reg <= RST;
        end else if (we) begin
            q_reg <= wdata;
        end
    end

    assign q = q_reg;

endmodule

// ===== ppal_top_props.sv
`timescale 1ns/1ps
`include "ppal_cfg.svh"

module ppal_top_props #(
    parameter int ADDR_W = 8
) (
    input wire logic                 mclk,
    input wire logic                 nrst,
    input wire logic                 hsel,
    input wire logic [ADDR_W-1:0]    haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic [2:0]           hsize,
    input wire logic                 hready,
    input wire logic [31:0]          hwdata,
    input wire logic [31:0]          hrdata,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    input wire logic                 pat_line_start,
    input wire logic                 pat_ready,
    input wire logic                 pat_valid,
    input wire ppal_pkg::ppal_byte_t pat_byte,
    input wire ppal_pkg::ppal_mode_t pat_mode
);
    import ppal_pkg::*;
    // ------------------------------
    // Bus and stream checks
    // ------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic       tk = hsel && hready && htrans[1];
    wire logic [5:0] ix = haddr[7:2];
    sequence rd_s;
        tk && !hwrite;
    endsequence
    sequence wr_s;
        tk && hwrite;
    endsequence
    AST_READY: assert property (hreadyout) else $error("wait state seen");
    AST_OKAY: assert property (!hresp) else $error("error response seen");
    AST_RD_PAL: assert property (rd_s ##0 (ix >= `PPAL_IDX_BYTE0 && ix <= `PPAL_IDX_BYTE14)
        |=> hrdata[31:8] == 24'h0) else $error("palette upper bits set");
    AST_RD_RSVD: assert property (rd_s ##0 (ix == `PPAL_IDX_RSVD) |=> hrdata == 32'h0)
        else $error("reserved slot not zero");
    AST_RD_UNMAP: assert property (rd_s ##0 (ix < `PPAL_IDX_BYTE0 || ix > `PPAL_IDX_STATUS)
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    AST_WR_FWD: assert property (wr_s ##0 (ix >= `PPAL_IDX_BYTE0 && ix <= `PPAL_IDX_BYTE14)
        ##1 (rd_s ##0 ix == $past(ix)) |=> hrdata[7:0] == $past(hwdata[7:0]))
        else $error("write not seen by next read");
    AST_MODE: assert property (wr_s ##0 (ix == `PPAL_IDX_CTRL) ##1 1'b1 |=> pat_mode == $past(hwdata[1:0]))
        else $error("mode not taken");
    // Mode changes may legally drop a held byte, so those cycles are left out
    AST_HOLD: assert property ((pat_valid && !pat_ready && !pat_line_start && $stable(pat_mode))
        ##1 $stable(pat_mode) |-> pat_valid && $stable(pat_byte)) else $error("byte not held");
    AST_OFF: assert property ((pat_mode == PPAL_MODE_OFF && pat_ready) [*3] |-> !pat_valid)
        else $error("stream while off");
endmodule

bind ppal_top ppal_top_props #(.ADDR_W(ADDR_W)) ppal_top_props_inst (
    .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pat_line_start(pat_line_start), .pat_ready(pat_ready),
    .pat_valid(pat_valid), .pat_byte(pat_byte), .pat_mode(pat_mode));

// ===== ppal_top_test.sv
`timescale 1ns/1ps
`include "ppal_cfg.svh"

module ppal_top_test;
    import ppal_pkg::*;
    localparam logic [7:0] A_CTRL = {`PPAL_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_B3   = {`PPAL_IDX_BYTE3, 2'b00};
    localparam logic [7:0] A_B5   = {`PPAL_IDX_BYTE5, 2'b00};
    localparam logic [7:0] A_B6   = {`PPAL_IDX_BYTE6, 2'b00};
    localparam logic [7:0] A_RS   = {`PPAL_IDX_RSVD, 2'b00};
    // Row: write flag, byte address, write data or expected read data
    localparam logic [40:0] ROWS [12] = '{
        {1'b0, `PPAL_IDX_BYTE0, 2'b00, 32'haa}, {1'b0, A_B3, 32'h7f},
        {1'b0, `PPAL_IDX_BYTE4, 2'b00, 32'h55}, {1'b0, A_B5, 32'hcc},
        {1'b0, `PPAL_IDX_BYTE7, 2'b00, 32'h80}, {1'b0, `PPAL_IDX_BYTE11, 2'b00, 32'h00},
        {1'b0, A_RS, 32'h0}, {1'b0, A_CTRL, 32'h000f_0e00}, {1'b1, A_RS, 32'hff},
        {1'b0, A_RS, 32'h0}, {1'b1, 8'h00, 32'h5a}, {1'b0, 8'h00, 32'h0}};
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        pat_ready = 1'b0;
    logic        pat_line_start = 1'b0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        pat_valid;
    ppal_byte_t  pat_byte;
    ppal_mode_t  pat_mode;
    logic [7:0]  pal [15];
    logic [31:0] rd;
    int          err_count = 0;
    int          checks_done = 0;

    ppal_top #(.ADDR_W(8)) ppal_top_inst (
        .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .pat_line_start(pat_line_start), .pat_ready(pat_ready), .pat_valid(pat_valid),
        .pat_byte(pat_byte), .pat_mode(pat_mode));

    initial forever #5 mclk = ~mclk;
    initial begin
        #200000;
        err_count++;
        stop_test();
    end
    // ------------------------------
    // Tasks
    // ------------------------------
    task stop_test;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wait_rdy;
        do @(posedge mclk); while (hready !== 1'b1);
    endtask
    // With b2b set, a read of the same address follows the write at once
    task ahb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic b2b);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= b2b ? 2'h2 : 2'h0;
        hwrite <= 1'b0;
        hwdata <= d;
        wait_rdy();
        if (b2b) begin
            htrans <= 2'h0;
            wait_rdy();
        end
        rd = hrdata;
    endtask
    // Consumer stalls one cycle in three so held bytes are exercised
    task stream(input int n, input int div, input int modn, input int base);
        int j;
        int k;
        j = 0;
        k = 0;
        while (j < n && k < 3000) begin
            @(negedge mclk);
            if (pat_valid === 1'b1 && pat_ready === 1'b1) begin
                chk(pat_byte, pal[((base + j) / div) % modn]);
                j++;
            end
            @(posedge mclk);
            pat_ready <= (j < n) && (k % 3 != 2);
            k++;
        end
        chk(j, n);
    endtask
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        foreach (ROWS[i]) begin
            ahb(ROWS[i][39:32], ROWS[i][40], ROWS[i][31:0], 1'b0);
            if (!ROWS[i][40]) chk(rd, ROWS[i][31:0]);
        end
        for (int i = 0; i < 15; i++) begin
            pal[i] = 8'h30 + 8'(i);
            ahb({`PPAL_IDX_BYTE0 + 6'(i), 2'b00}, 1'b1, {24'h0, pal[i]}, 1'b0);
        end
        ahb(A_B6, 1'b1, 32'h0000_01a6, 1'b1);
        chk(rd, 32'h0000_00a6);
        pal[6] = 8'ha6;
        ahb(A_CTRL, 1'b1, 32'h0001_0e01, 1'b0);
        stream(40, 2, 8, 0);
        @(posedge mclk);
        pat_ready <= 1'b1;
        ahb(A_CTRL, 1'b1, 32'h0000_0e00, 1'b0);
        repeat (4) @(posedge mclk);
        pat_ready <= 1'b0;
        ahb(A_CTRL, 1'b1, 32'h0000_0e02, 1'b0);
        stream(30, 1, 15, 0);
        ahb(A_B5, 1'b1, 32'h99, 1'b0);
        pal[5] = 8'h99;
        stream(30, 1, 15, 30);
        // Line start while a byte is held: held byte stays, then the sequence restarts at 0
        pat_line_start <= 1'b1;
        @(posedge mclk);
        pat_line_start <= 1'b0;
        stream(1, 1, 15, 0);
        stream(29, 1, 15, 0);
        @(posedge mclk);
        pat_ready <= 1'b1;
        ahb(A_CTRL, 1'b1, 32'h0000_0e00, 1'b0);
        // Reserved mode code must not stream
        ahb(A_CTRL, 1'b1, 32'h0000_0e03, 1'b0);
        repeat (4) @(posedge mclk);
        chk(32'(pat_valid), 32'h0);
        chk(32'(pat_mode), 32'h3);
        ahb(A_CTRL, 1'b1, 32'h0000_0e00, 1'b0);
        repeat (4) @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        ahb(A_B3, 1'b0, 32'h0, 1'b0);
        chk(rd, 32'h7f);
        stop_test();
    end
endmodule
